// >>> hdl/sxa_alu.sv
// Purpose: execute stage for literal/file subtract, xor and nibble swap
// Assumes: decoder holds a command until CMD_READY; file memory is internal
// Notes: file ops take two cycles (fetch, execute); literal ops take one
`timescale 1ns/1ps
// Contract
// [RQ1] literal minus accumulator goes to the accumulator and updates carry, half carry and zero.
// [RQ2] literal xor accumulator goes to the accumulator and updates only zero.
// [RQ3] file minus accumulator updates carry, half carry and zero from the result.
// [RQ4] file xor accumulator updates only zero and keeps carry and half carry.
// [RQ5] nibble swap exchanges the two nibbles of the file value and keeps all flags.
// [RQ6] for file operations dest 0 writes the accumulator and dest 1 writes the file register.
// [RQ7] zero is set for a zero result; carry and half carry mean no borrow out of bit 7 and bit 3.
module sxa_alu #(
  parameter int DEPTH = sxa_pkg::FILE_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // command from decoder
  input wire logic CMD_VALID,
  input wire sxa_pkg::sxa_cmd_t CMD,
  output logic CMD_READY,
  // state visible to the core
  output logic [7:0] ACC,
  output sxa_pkg::sxa_flags_t FLAGS,
  output logic DONE,
  // file write snoop
  output logic FILE_WE,
  output logic [6:0] FILE_WADDR,
  output logic [7:0] FILE_WDATA
);
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } sxa_state_t;

  sxa_state_t state_reg, state_next;
  logic [7:0] acc_reg, acc_next;
  sxa_pkg::sxa_flags_t flags_reg, flags_next;
  logic done_reg, done_next;
  sxa_pkg::sxa_cmd_t cmd_reg, cmd_next; // command seen at the last edge, read by the zero check
  logic we_reg, we_next;
  logic [6:0] waddr_reg, waddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [7:0] file_rd;
  logic [7:0] res;
  logic [8:0] sub9;
  logic [4:0] sub5;

  // a - b with no-borrow carries
  function automatic logic [8:0] sub_full(input logic [7:0] a, input logic [7:0] b);
    return {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction

  function automatic logic [4:0] sub_low(input logic [3:0] a, input logic [3:0] b);
    return {1'b0, a} + {1'b0, ~b} + 5'h01;
  endfunction

  sxa_file_mem #(.DEPTH(DEPTH), .AW(sxa_pkg::ADDR_W)) u_mem (
    .clk(CLK),
    .ce(CE),
    .rd_addr(CMD.addr),
    .rd_data(file_rd),
    .wr_en(we_reg),
    .wr_addr(waddr_reg),
    .wr_data(wdata_reg)
  );

  // handshake: literal ops taken at once, file ops after the fetch cycle
  always_comb begin
    CMD_READY = 1'b0;
    if (CE && CMD_VALID) begin
      if (CMD.op == sxa_pkg::SXA_LIT_SUB || CMD.op == sxa_pkg::SXA_LIT_XOR
          || CMD.op == sxa_pkg::SXA_NOP) begin
        CMD_READY = 1'b1;
      end else begin
        CMD_READY = (state_reg == ST_EXEC);
      end
    end
  end

  // next-state, result and flag computation
  always_comb begin
    state_next = state_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    done_next = 1'b0;
    cmd_next = CMD;
    we_next = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    res = 8'h00;
    sub9 = 9'h000;
    sub5 = 5'h00;
    if (CMD_VALID) begin
      case (CMD.op)
        sxa_pkg::SXA_LIT_SUB: begin
          sub9 = sub_full(CMD.literal, acc_reg); // [RQ1]
          sub5 = sub_low(CMD.literal[3:0], acc_reg[3:0]);
          acc_next = sub9[7:0];
          flags_next.carry = sub9[8]; // [RQ7]
          flags_next.half_carry_flag = sub5[4]; // [RQ7]
          flags_next.zero = (sub9[7:0] == 8'h00); // [RQ7]
          done_next = 1'b1;
        end
        sxa_pkg::SXA_LIT_XOR: begin
          acc_next = acc_reg ^ CMD.literal; // [RQ2]
          flags_next.zero = ((acc_reg ^ CMD.literal) == 8'h00); // [RQ2]
          done_next = 1'b1;
        end
        sxa_pkg::SXA_FILE_SUB, sxa_pkg::SXA_FILE_XOR, sxa_pkg::SXA_SWAP: begin
          if (state_reg == ST_IDLE) begin
            state_next = ST_EXEC; // file data arrives next cycle
          end else begin
            state_next = ST_IDLE;
            done_next = 1'b1;
            case (CMD.op)
              sxa_pkg::SXA_FILE_SUB: begin
                sub9 = sub_full(file_rd, acc_reg); // [RQ3]
                sub5 = sub_low(file_rd[3:0], acc_reg[3:0]);
                res = sub9[7:0];
                flags_next.carry = sub9[8]; // [RQ3] [RQ7]
                flags_next.half_carry_flag = sub5[4];
                flags_next.zero = (sub9[7:0] == 8'h00);
              end
              sxa_pkg::SXA_FILE_XOR: begin
                res = acc_reg ^ file_rd; // [RQ4]
                flags_next.zero = (res == 8'h00); // [RQ4]
              end
              default: begin
                res = {file_rd[sxa_pkg::NIB_LO +: 4], file_rd[sxa_pkg::NIB_HI +: 4]}; // [RQ5]
              end
            endcase
            if (CMD.dest == sxa_pkg::DEST_ACC) begin
              acc_next = res; // [RQ6]
            end else begin
              we_next = 1'b1; // [RQ6]
              waddr_next = CMD.addr;
              wdata_next = res;
            end
          end
        end
        default: begin
          done_next = 1'b0;
        end
      endcase
    end else begin
      state_next = ST_IDLE;
    end
  end

  // state registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      acc_reg <= sxa_pkg::ACC_RESET;
      flags_reg <= '0;
      done_reg <= 1'b0;
      cmd_reg <= '0;
      we_reg <= 1'b0;
      waddr_reg <= 7'h00;
      wdata_reg <= sxa_pkg::FILE_RESET;
    end else if (CE) begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      done_reg <= done_next;
      cmd_reg <= cmd_next;
      we_reg <= we_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  assign ACC = acc_reg;
  assign FLAGS = flags_reg;
  assign DONE = done_reg;
  assign FILE_WE = we_reg;
  assign FILE_WADDR = waddr_reg;
  assign FILE_WDATA = wdata_reg;

  // operand copies one edge old, so the checks below see what the taking edge saw
  logic [7:0] lit_prev, acc_prev, file_prev;
  always_ff @(posedge CLK) begin
    lit_prev <= CMD.literal;
    acc_prev <= acc_reg;
    file_prev <= file_rd;
  end

  property p_lit_sub;
    @(posedge CLK) disable iff (!RST_N)
    (CE && CMD_VALID && CMD_READY && CMD.op == sxa_pkg::SXA_LIT_SUB) |=>
      (ACC == 8'(lit_prev - acc_prev)) && (FLAGS.carry == (lit_prev >= acc_prev));
  endproperty
  a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong"); // [RQ1]

  property p_lit_xor;
    @(posedge CLK) disable iff (!RST_N)
    (CE && CMD_VALID && CMD.op == sxa_pkg::SXA_LIT_XOR) |=>
      (ACC == (lit_prev ^ acc_prev)) && $stable(FLAGS.carry) && $stable(FLAGS.half_carry_flag);
  endproperty
  a_lit_xor: assert property (p_lit_xor) else $error("literal xor wrong"); // [RQ2]

  property p_file_sub;
    @(posedge CLK) disable iff (!RST_N)
    (CE && CMD_READY && CMD.op == sxa_pkg::SXA_FILE_SUB) |=>
      (FLAGS.half_carry_flag == (file_prev[3:0] >= acc_prev[3:0]));
  endproperty
  a_file_sub: assert property (p_file_sub) else $error("file subtract flags wrong"); // [RQ3]

  property p_file_xor;
    @(posedge CLK) disable iff (!RST_N)
    (CE && CMD_READY && CMD.op == sxa_pkg::SXA_FILE_XOR) |=>
      $stable(FLAGS.carry) && $stable(FLAGS.half_carry_flag);
  endproperty
  a_file_xor: assert property (p_file_xor) else $error("file xor touched carries"); // [RQ4]

  property p_swap;
    @(posedge CLK) disable iff (!RST_N)
    (CE && CMD_READY && CMD.op == sxa_pkg::SXA_SWAP && CMD.dest) |=>
      $stable(FLAGS) && FILE_WE && (FILE_WDATA == {file_prev[3:0], file_prev[7:4]});
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong"); // [RQ5]

  property p_dest_acc;
    @(posedge CLK) disable iff (!RST_N)
    (CE && CMD_READY && CMD.op != sxa_pkg::SXA_NOP && !CMD.dest) |=> !FILE_WE;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("dest 0 wrote file"); // [RQ6]

  property p_zero;
    @(posedge CLK) disable iff (!RST_N)
    $rose(DONE) && cmd_reg.op != sxa_pkg::SXA_SWAP && !cmd_reg.dest |->
      (FLAGS.zero == (ACC == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RQ7]
endmodule

// >>> hdl/sxa_file_mem.sv
// Purpose: file register memory with registered read data
// Assumes: one read and one write port, same clock
// Notes: write data visible on read one cycle after the write
`timescale 1ns/1ps
module sxa_file_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock and enable
  input wire logic clk,
  input wire logic ce,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] mem [DEPTH];

  // storage and registered read
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// >>> hdl/sxa_pkg.sv
// Purpose: shared types and constants for the subtract/xor/swap datapath
// Assumes: 8-bit data, 7-bit file addresses
// Notes: opcodes are local encodings chosen for this block
package sxa_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    SXA_NOP = 3'b000,
    SXA_LIT_SUB = 3'b001,
    SXA_LIT_XOR = 3'b010,
    SXA_FILE_SUB = 3'b011,
    SXA_FILE_XOR = 3'b100,
    SXA_SWAP = 3'b101
  } sxa_op_t;

  typedef struct packed {
    sxa_op_t op;
    logic [7:0] literal;
    logic [6:0] addr;
    logic dest;
  } sxa_cmd_t;

  typedef struct packed {
    logic zero;
    logic half_carry_flag;
    logic carry;
  } sxa_flags_t;
endpackage

// >>> tb/sxa_dec_model.sv
// Purpose: decoder model that hands commands to the datapath
// Assumes: called just after a rising edge; holds each command until ready
// Notes: idle inverts the lines, so one idle gives the inverse of the last command and a second idle in a row restores it
`timescale 1ns/1ps
module sxa_dec_model (
  // clock
  input wire logic clk,
  // command to the datapath
  output logic cmd_valid,
  output sxa_pkg::sxa_cmd_t cmd,
  input wire logic cmd_ready,
  // set when a command was never taken
  output logic stuck
);
  // quiet lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    stuck = 1'b0;
  end

  // present one command and hold it until the edge that takes it
  task automatic send(input sxa_pkg::sxa_cmd_t c);
    logic rdy;
    int n;
    rdy = 1'b0;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= c;
    while (!rdy && n < 8) begin
      @(negedge clk);
      rdy = (cmd_ready === 1'b1);
      @(posedge clk);
      n++;
    end
    if (!rdy) stuck = 1'b1;
  endtask

  // drop valid for one cycle, lines go to a changed pattern
  task automatic idle();
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
    @(posedge clk);
  endtask
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench for the subtract/xor/swap datapath
// Assumes: file memory is seeded with the file reset value before reset ends
// Notes: a reference model queues results; a monitor compares on done
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] acc;
    sxa_pkg::sxa_flags_t fl;
    logic we;
    logic [6:0] wa;
    logic [7:0] wd;
  } sxa_exp_t;
  logic clk, rst_n, ce, cmd_valid, cmd_ready, done, file_we, stuck;
  sxa_pkg::sxa_cmd_t cmd;
  sxa_pkg::sxa_op_t op;
  logic [7:0] acc, file_wdata, m_acc;
  logic [6:0] file_waddr;
  sxa_pkg::sxa_flags_t flags, m_fl;
  logic [7:0] m_mem [128];
  logic [15:0] tbl [6] = '{16'h0000, 16'h0100, 16'h0110, 16'h100F, 16'hFFFF, 16'h807F};
  int failures, num_checks, seed;
  sxa_exp_t exp_q[$];
  sxa_exp_t got;

  sxa_alu dut_u (.CLK(clk), .RST_N(rst_n), .CE(ce), .CMD_VALID(cmd_valid), .CMD(cmd),
    .CMD_READY(cmd_ready), .ACC(acc), .FLAGS(flags), .DONE(done), .FILE_WE(file_we),
    .FILE_WADDR(file_waddr), .FILE_WDATA(file_wdata));
  sxa_dec_model dec_u (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .stuck(stuck));

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // verdict and end of run
  task automatic end_of_test();
    if (stuck === 1'b1) failures++;
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one comparison, counted
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, e, s);
    end
  endtask

  // model the operation, queue its result, then hand it to the decoder
  task automatic issue(input sxa_pkg::sxa_op_t o, input logic [7:0] k, input logic [6:0] a,
                       input logic d);
    sxa_pkg::sxa_cmd_t c;
    sxa_exp_t e;
    logic [7:0] src, r;
    logic fop;
    fop = (o inside {sxa_pkg::SXA_FILE_SUB, sxa_pkg::SXA_FILE_XOR, sxa_pkg::SXA_SWAP});
    src = fop ? m_mem[a] : k;
    case (o)
      sxa_pkg::SXA_LIT_SUB, sxa_pkg::SXA_FILE_SUB: begin
        r = src - m_acc;
        m_fl.carry = (src >= m_acc); // no borrow out of bit 7
        m_fl.half_carry_flag = (src[3:0] >= m_acc[3:0]); // no borrow out of bit 3
        m_fl.zero = (r == 8'h00);
      end
      sxa_pkg::SXA_SWAP: r = {src[3:0], src[7:4]};
      default: begin
        r = src ^ m_acc;
        m_fl.zero = (r == 8'h00);
      end
    endcase
    e.we = fop && (d == sxa_pkg::DEST_FILE);
    if (e.we) m_mem[a] = r;
    else m_acc = r;
    e.acc = m_acc;
    e.fl = m_fl;
    e.wa = a;
    e.wd = r;
    exp_q.push_back(e);
    c.op = o;
    c.literal = k;
    c.addr = a;
    c.dest = d;
    dec_u.send(c);
    if (stuck === 1'b1) end_of_test();
    if (e.we) dec_u.idle(); // let the file write land before the next fetch
  endtask

  // monitor: oldest note against each completed result
  always @(negedge clk) begin
    if (rst_n && done === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious done", 32'h0, 32'h1);
      else begin
        got = exp_q.pop_front();
        chk("acc", got.acc, acc);
        chk("flags", got.fl, flags);
        chk("file_we", got.we, file_we);
        if (got.we) chk("file write", {got.wa, got.wd}, {file_waddr, file_wdata});
      end
    end else if (rst_n) chk("idle file_we", 32'h0, file_we);
  end

  // reset, directed flag boundaries, then random mix
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    failures = 0;
    num_checks = 0;
    m_acc = sxa_pkg::ACC_RESET;
    m_fl = '0;
    for (int i = 0; i < 128; i++) m_mem[i] = sxa_pkg::FILE_RESET;
    // the file memory has no reset: seed it to match the model
    for (int i = 0; i < 128; i++) dut_u.u_mem.mem[i] = sxa_pkg::FILE_RESET;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset state", {sxa_pkg::ACC_RESET, 4'h0}, {acc, flags, done});
    @(posedge clk);
    seed = $urandom(80);
    for (int i = 0; i < 6; i++) begin
      issue(sxa_pkg::SXA_LIT_XOR, m_acc ^ tbl[i][15:8], 7'h00, 1'b0);
      issue(sxa_pkg::SXA_LIT_SUB, tbl[i][7:0], 7'h00, 1'b0);
    end
    // a no-op must leave acc and flags alone and raise no done
    dec_u.send(sxa_pkg::sxa_cmd_t'({sxa_pkg::SXA_NOP, 8'hA5, 7'h00, 1'b0}));
    dec_u.idle();
    // freeze the core for three edges with a command waiting
    ce <= 1'b0;
    fork
      begin
        repeat (3) begin
          @(negedge clk);
          chk("ready while frozen", 32'h0, cmd_ready);
        end
        @(posedge clk);
        ce <= 1'b1;
      end
    join_none
    issue(sxa_pkg::SXA_LIT_SUB, 8'h5A, 7'h00, 1'b0);
    for (int i = 0; i < 200; i++) begin
      op = sxa_pkg::sxa_op_t'(3'($urandom_range(5, 1)));
      issue(op, 8'($urandom), (i % 5 == 4) ? 7'h7F : 7'($urandom_range(3)), 1'($urandom));
    end
    dec_u.idle();
    repeat (4) @(posedge clk);
    chk("pending results", 32'h0, exp_q.size());
    end_of_test();
  end
endmodule
